// *** dscg_gate_cell.sv ***
// Glitch-free clock gate for one unit, clock made at half the bus rate
`timescale 1ns/100ps
module dscg_gate_cell (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request and gated clock
  input wire logic en_req,
  output logic en_q,
  output logic clk_q
);
  // Enable may change only while the unit clock is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else if (!clk_q) begin
      en_q <= en_req;
    end
  end

  // Toggle only while enabled, so every pulse is full width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
    end else begin
      // No new rising half once the request has dropped
      clk_q <= (en_q && (clk_q || en_req)) ? ~clk_q : 1'b0;
    end
  end
endmodule : dscg_gate_cell

// *** dscg_pkg.sv ***
// Package for the deep-sleep clock-gating block: offsets, fields, types
package dscg_pkg;
  localparam int unsigned DSCG_UNITS = 5;
  // Register offsets
  localparam logic [11:0] DSCG_OFF_CFG = 12'h060;
  localparam logic [11:0] DSCG_OFF_RUN = 12'h100;
  localparam logic [11:0] DSCG_OFF_SLP = 12'h110;
  localparam logic [11:0] DSCG_OFF_DSL = 12'h120;
  localparam logic [11:0] DSCG_OFF_STAT = 12'h130;
  localparam logic [11:0] DSCG_OFF_MASK = 12'h134;
  // Gating fields
  localparam int unsigned DSCG_BIT_WATCHDOG = 3;
  localparam int unsigned DSCG_BIT_HIBERNATION = 6;
  localparam int unsigned DSCG_BIT_PWM = 20;
  localparam int unsigned DSCG_BIT_CANA = 24;
  localparam int unsigned DSCG_BIT_CANB = 25;
  localparam int unsigned DSCG_BIT_AUTO_GATE = 27;
  localparam int unsigned DSCG_UNIT_BIT [DSCG_UNITS] = '{DSCG_BIT_WATCHDOG, DSCG_BIT_HIBERNATION,
    DSCG_BIT_PWM, DSCG_BIT_CANA, DSCG_BIT_CANB};
  localparam logic [31:0] DSCG_GATE_WMASK = 32'h03100048;
  localparam logic [31:0] DSCG_GATE_RESET = 32'h00000040;
  localparam logic [31:0] DSCG_CFG_WMASK = 32'h08000000;
  localparam logic [31:0] DSCG_CFG_RESET = 32'h00000000;
  localparam logic [DSCG_UNITS-1:0] DSCG_IRQ_RESET = 5'h00;
  localparam int unsigned DSCG_SYNC_STAGES = 3;

  // Power state, Gray coded along run -> sleep -> deep-sleep
  typedef enum logic [1:0] {
    DSCG_PWR_RUN = 2'b00,
    DSCG_PWR_SLEEP = 2'b01,
    DSCG_PWR_DEEP = 2'b11
  } dscg_pwr_e;

  // One bit per gated unit, index 0 is the watchdog
  typedef struct packed {
    logic bus_controller_b;
    logic bus_controller_a;
    logic pwm;
    logic hibernation;
    logic watchdog;
  } dscg_units_s;

  // APB response
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dscg_apb_rsp_s;
endpackage : dscg_pkg

// *** dscg_top.sv ***
// Deep-sleep clock-gating register block with APB slave
// Notes on behaviour
// - Deep-sleep gating register at 0x120; bits 25, 24, 20 gate bus controllers, PWM.
// - Bit one clocks the unit; bit zero stops its clock.
// - An access to an unclocked unit is answered with a bus fault.
// - Gating bits reset to zero unless stated otherwise.
// - Bit 6 gates hibernation, writable, resets to one; register resets 0x00000040.
// - Bit 3 gates the watchdog, resets zero, faults when unclocked.
// - Run, sleep or deep-sleep register applies according to power state.
// - Sleep registers apply only with auto gating set, else run register.
// - Reserved bits are read-only zero; software preserves them.
`timescale 1ns/100ps
module dscg_top
  import dscg_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // APB response
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power state pins
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  // Unit access from the system bus
  input wire dscg_units_s unit_access,
  output dscg_units_s unit_fault,
  // Gated unit clocks and enables
  output dscg_units_s unit_clk,
  output dscg_units_s unit_clk_en,
  // Interrupt
  output logic irq
);
  logic [31:0] run_unit_clock_enable_q;
  logic [31:0] sleep_unit_clock_enable_q;
  logic [31:0] deep_sleep_unit_clock_enable_q;
  logic [31:0] run_clock_configuration_q;
  logic [DSCG_UNITS-1:0] fault_stat_q;
  logic [DSCG_UNITS-1:0] fault_mask_q;
  logic [DSCG_SYNC_STAGES-1:0] slp_sync_q;
  logic [DSCG_SYNC_STAGES-1:0] dsl_sync_q;
  logic slp_q;
  logic dsl_q;
  dscg_pwr_e pwr_q;
  dscg_pwr_e pwr_d;
  logic [31:0] active_d;
  logic [DSCG_UNITS-1:0] unit_req;
  logic [DSCG_UNITS-1:0] unit_en;
  logic [DSCG_UNITS-1:0] unit_clk_w;
  logic [DSCG_UNITS-1:0] fault_d;
  logic [DSCG_UNITS-1:0] fault_q;
  logic wr_en;
  logic setup;
  dscg_apb_rsp_s rsp_d;
  dscg_apb_rsp_s rsp_q;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  // Power-state pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_sync_q <= '0;
      dsl_sync_q <= '0;
    end else begin
      slp_sync_q <= {slp_sync_q[DSCG_SYNC_STAGES-2:0], sleep_mode};
      dsl_sync_q <= {dsl_sync_q[DSCG_SYNC_STAGES-2:0], deep_sleep_mode};
    end
  end

  // Accept a pin level once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_q <= 1'b0;
      dsl_q <= 1'b0;
    end else begin
      if (slp_sync_q[1] == slp_sync_q[2]) begin
        slp_q <= slp_sync_q[2];
      end
      if (dsl_sync_q[1] == dsl_sync_q[2]) begin
        dsl_q <= dsl_sync_q[2];
      end
    end
  end

  // Power state tracking
  always_comb begin
    case (pwr_q)
      DSCG_PWR_RUN: begin
        pwr_d = (slp_q | dsl_q) ? DSCG_PWR_SLEEP : DSCG_PWR_RUN;
      end
      DSCG_PWR_SLEEP: begin
        if (dsl_q) begin
          pwr_d = DSCG_PWR_DEEP;
        end else if (slp_q) begin
          pwr_d = DSCG_PWR_SLEEP;
        end else begin
          pwr_d = DSCG_PWR_RUN;
        end
      end
      DSCG_PWR_DEEP: begin
        if (dsl_q) begin
          pwr_d = DSCG_PWR_DEEP;
        end else begin
          pwr_d = slp_q ? DSCG_PWR_SLEEP : DSCG_PWR_RUN;
        end
      end
      default: begin
        pwr_d = DSCG_PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= DSCG_PWR_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Gating registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_unit_clock_enable_q <= DSCG_GATE_RESET;
      sleep_unit_clock_enable_q <= DSCG_GATE_RESET;
      deep_sleep_unit_clock_enable_q <= DSCG_GATE_RESET;
      run_clock_configuration_q <= DSCG_CFG_RESET;
    end else if (wr_en) begin
      case (paddr)
        DSCG_OFF_RUN: run_unit_clock_enable_q <= pwdata & DSCG_GATE_WMASK;
        DSCG_OFF_SLP: sleep_unit_clock_enable_q <= pwdata & DSCG_GATE_WMASK;
        DSCG_OFF_DSL: deep_sleep_unit_clock_enable_q <= pwdata & DSCG_GATE_WMASK;
        DSCG_OFF_CFG: run_clock_configuration_q <= pwdata & DSCG_CFG_WMASK;
        default: begin
        end
      endcase
    end
  end

  // Select the active gating set
  always_comb begin
    if (!run_clock_configuration_q[DSCG_BIT_AUTO_GATE]) begin
      active_d = run_unit_clock_enable_q;
    end else begin
      case (pwr_q)
        DSCG_PWR_SLEEP: active_d = sleep_unit_clock_enable_q;
        DSCG_PWR_DEEP: active_d = deep_sleep_unit_clock_enable_q;
        default: active_d = run_unit_clock_enable_q;
      endcase
    end
  end

  // One gate cell per unit
  generate
    for (genvar u = 0; u < DSCG_UNITS; u++) begin : g_unit
      assign unit_req[u] = active_d[DSCG_UNIT_BIT[u]];
      dscg_gate_cell u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .en_req(unit_req[u]),
        .en_q(unit_en[u]),
        .clk_q(unit_clk_w[u])
      );
    end
  endgenerate

  assign unit_clk = dscg_units_s'(unit_clk_w);
  assign unit_clk_en = dscg_units_s'(unit_en);

  // Accesses to unclocked units fault
  assign fault_d = unit_access & ~unit_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault_d;
    end
  end

  assign unit_fault = dscg_units_s'(fault_q);

  // Sticky fault status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_stat_q <= DSCG_IRQ_RESET;
    end else if (wr_en && paddr == DSCG_OFF_STAT) begin
      fault_stat_q <= (fault_stat_q & ~pwdata[DSCG_UNITS-1:0]) | fault_d;
    end else begin
      fault_stat_q <= fault_stat_q | fault_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_mask_q <= DSCG_IRQ_RESET;
    end else if (wr_en && paddr == DSCG_OFF_MASK) begin
      fault_mask_q <= pwdata[DSCG_UNITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(fault_stat_q & fault_mask_q);
    end
  end

  // Read decode, reserved bits read zero
  always_comb begin
    rsp_d = '0;
    rsp_d.pready = setup;
    case (paddr)
      DSCG_OFF_RUN: rsp_d.prdata = run_unit_clock_enable_q;
      DSCG_OFF_SLP: rsp_d.prdata = sleep_unit_clock_enable_q;
      DSCG_OFF_DSL: rsp_d.prdata = deep_sleep_unit_clock_enable_q;
      DSCG_OFF_CFG: rsp_d.prdata = run_clock_configuration_q;
      DSCG_OFF_STAT: rsp_d.prdata = {27'h0000000, fault_stat_q};
      DSCG_OFF_MASK: rsp_d.prdata = {27'h0000000, fault_mask_q};
      default: rsp_d.pslverr = 1'b1;
    endcase
  end

  // Answer registered in the setup cycle, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else if (setup) begin
      rsp_q <= rsp_d;
    end else begin
      rsp_q <= '0;
    end
  end

  assign prdata = rsp_q.prdata;
  assign pready = rsp_q.pready;
  assign pslverr = rsp_q.pslverr;
endmodule : dscg_top

// *** dscg_top_properties.sv ***
// Checker for the deep-sleep clock-gating block
`timescale 1ns/100ps
module dscg_top_properties
  import dscg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Units
  input wire dscg_units_s unit_access,
  input wire dscg_units_s unit_fault,
  input wire dscg_units_s unit_clk,
  input wire dscg_units_s unit_clk_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no access answer");
  AST_ONECYC: assert property (pready |=> !pready)
    else $error("pready held");
  AST_FAULT: assert property (unit_fault == ($past(unit_access) & ~$past(unit_clk_en)))
    else $error("fault mismatch");
  AST_WDT: assert property (unit_access.watchdog && !unit_clk_en.watchdog |=> unit_fault.watchdog)
    else $error("watchdog fault missing");
  AST_NOCLK: assert property ((unit_clk & ~unit_clk_en) == 5'h00)
    else $error("clock while disabled");
  AST_TOGGLE: assert property (unit_clk_en.hibernation && $past(unit_clk_en.hibernation)
    |-> unit_clk.hibernation != $past(unit_clk.hibernation))
    else $error("enabled clock stuck");
  AST_GLITCH: assert property (($past(unit_clk) & (unit_clk_en ^ $past(unit_clk_en))) == 5'h00)
    else $error("enable moved while clock high");
  AST_RSVD: assert property (pready && paddr == DSCG_OFF_DSL
    |-> (prdata & ~DSCG_GATE_WMASK) == 32'h00000000)
    else $error("reserved bit set");
  AST_DSLOK: assert property (pready && paddr == DSCG_OFF_DSL |-> !pslverr)
    else $error("gating register refused");
endmodule : dscg_top_properties
bind dscg_top dscg_top_properties i_dscg_top_properties (.*);

// *** dscg_top_tb.sv ***
// Self-checking bench for the deep-sleep clock-gating block
`timescale 1ns/100ps
module dscg_top_tb
  import dscg_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic sleep_mode = 0, deep_sleep_mode = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, irq, err;
  dscg_units_s unit_access = 5'h00, unit_fault, unit_clk, unit_clk_en;
  int fail_count = 0, comparisons = 0;
  always #50 pclk = ~pclk;
  dscg_top i_dscg_top (.*);

  task results;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task hit(input logic [4:0] m);
    @(posedge pclk);
    unit_access <= m;
    @(posedge pclk);
    unit_access <= 5'h00;
    #1;
  endtask : hit

  task pwr(input logic s, input logic d);
    @(posedge pclk);
    sleep_mode <= s;
    deep_sleep_mode <= d;
    repeat (12) @(posedge pclk);
  endtask : pwr

  task t_regs;
    xfer(0, 12'h120, 0);
    chk(rd, 32'h00000040);
    xfer(1, 12'h120, 32'hFFFFFFFF);
    xfer(0, 12'h120, 0);
    chk(rd, 32'h03100048);
    xfer(1, 12'h120, 32'h00000000);
    xfer(0, 12'h120, 0);
    chk(rd, 32'h00000000);
    xfer(0, 12'hFFC, 0);
    chk(32'(err), 32'h1);
  endtask : t_regs

  task t_fault;
    xfer(1, 12'h134, 32'h1F);
    xfer(1, 12'h100, 32'h0);
    repeat (4) @(posedge pclk);
    chk(32'(unit_clk_en), 32'h0);
    for (int u = 0; u < 5; u++) begin
      hit(5'h01 << u);
      chk(32'(unit_fault), 32'h1 << u);
    end
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    xfer(0, 12'h130, 0);
    chk(rd, 32'h1F);
    xfer(1, 12'h134, 32'h0);
    xfer(1, 12'h130, 32'h1F);
    hit(5'h01);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    xfer(1, 12'h130, 32'h1F);
    xfer(1, 12'h100, 32'h08);
    repeat (4) @(posedge pclk);
    hit(5'h01);
    chk(32'(unit_fault), 32'h0);
  endtask : t_fault

  task t_power;
    pwr(0, 1);
    chk(32'(unit_clk_en), 32'h01);
    xfer(1, 12'h060, 32'h08000000);
    repeat (6) @(posedge pclk);
    chk(32'(unit_clk_en), 32'h00);
    xfer(1, 12'h120, 32'h02000000);
    repeat (6) @(posedge pclk);
    chk(32'(unit_clk_en), 32'h10);
    pwr(1, 0);
    chk(32'(unit_clk_en), 32'h02);
    pwr(0, 0);
    chk(32'(unit_clk_en), 32'h01);
  endtask : t_power

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fault();
    t_power();
    results();
  end
endmodule : dscg_top_tb
